// ### logic/sbl_consts.svh
// Constants of the serial boot loader: presets, addresses, timing counts.
// Assumes a single 100 MHz core clock; included by the loader file only.
`ifndef SBL_CONSTS_SVH
`define SBL_CONSTS_SVH

`define SBL_STACK_TOP       16'hFA40
`define SBL_STACK_LIMIT     16'hFA0C
`define SBL_SERIAL_CTRL     16'h8011
`define SBL_LOAD_BASE       24'h00FA40
`define SBL_LOAD_LAST       24'h00FA5F
`define SBL_RESET_FETCH     24'h000000
`define SBL_LOAD_BYTES      6'h20
`define SBL_CAL_OFFSET      16'h0024
`define SBL_CAL_DIVISOR     16'h0048
`define SBL_BIT_MULT        21'h000020
`define SBL_TMR_PRESCALE    2'h3
`define SBL_SAMPLE_DELAY    2'h3
`define SBL_DATA_BITS       4'h8
`define SBL_TX_BITS         4'hA

`endif

// ### logic/sbl_pkg.sv
// Types shared by the serial boot loader.
// Assumes nothing beyond a SystemVerilog compiler.
package sbl_pkg;

   typedef enum logic [7:0] {
      SBL_ST_POR      = 8'h01,
      SBL_ST_NORMAL   = 8'h02,
      SBL_ST_CAL_WAIT = 8'h04,
      SBL_ST_CAL_MEAS = 8'h08,
      SBL_ST_ID_TX    = 8'h10,
      SBL_ST_LOAD     = 8'h20,
      SBL_ST_RUN      = 8'h40,
      SBL_ST_SPARE    = 8'h80
   } sbl_state_t;

   typedef struct packed {
      logic to_ram;
      logic [23:0] addr;
      logic [7:0] data;
   } sbl_word_t;

endpackage

// ### logic/sbl_loader.sv
// Serial boot loader: boot entry, baud calibration, identification, code load.
// Assumes one 100 MHz clock, async active-low system reset, pins synchronised here.

`include "sbl_consts.svh"

// ***************************************************************
// Receive FIFO
// ***************************************************************
module sbl_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign o_in_ready = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem_r[rd_ptr_r];

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ***************************************************************
// Boot loader top
// ***************************************************************
module sbl_loader
   import sbl_pkg::*;
#(
   parameter logic [7:0] ID_BYTE = 8'h3C, // Arbitrary identification value
   parameter int FIFO_DEPTH = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_sw_reset,
   input wire logic i_boot_select_pin,
   input wire logic i_serial_receive_pin,
   output logic o_serial_transmit_pin,
   output logic o_serial_transmit_oe,
   output logic o_transmit_pin_latch,
   output logic o_transmit_pin_direction,
   output logic o_boot_mode,
   output logic o_watchdog_disable,
   output logic o_code_mem_restrict,
   output logic [15:0] o_stack_top_pointer,
   output logic [15:0] o_stack_limit_setting,
   output logic [15:0] o_serial_control_setting,
   output logic [15:0] o_baud_reload_value,
   output logic o_calib_overflow,
   output logic o_rx_overrun,
   output logic o_exec_start,
   output logic [23:0] o_fetch_addr,
   output logic o_load_valid,
   input wire logic i_load_ready,
   output sbl_word_t o_load_word
);

   function automatic logic [15:0] calc_reload(input logic [15:0] cnt);
      calc_reload = (cnt >= `SBL_CAL_OFFSET) ?
                    (cnt - `SBL_CAL_OFFSET) / `SBL_CAL_DIVISOR : 16'h0000;
   endfunction

   sbl_state_t state_r;
   logic [1:0] sel_sync_r;
   logic [1:0] rx_sync_r;
   logic rx_prev_r;
   logic rx_s;
   logic rx_fall;
   logic rx_rise;
   logic [1:0] smp_cnt_r;
   logic [1:0] presc_r;
   logic [15:0] tmr_r;
   logic [20:0] bit_clks;
   logic [20:0] tx_cnt_r;
   logic [3:0] tx_idx_r;
   logic [9:0] tx_shift_r;
   logic tx_busy_r;
   logic rx_busy_r;
   logic [20:0] rx_cnt_r;
   logic [3:0] rx_idx_r;
   logic [7:0] rx_shift_r;
   logic rx_pend_r;
   sbl_word_t rx_word_r;
   logic rx_done;
   logic rx_en;
   logic [5:0] push_cnt_r;
   logic [5:0] load_cnt_r;
   logic fifo_in_ready;
   logic load_take;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sel_sync_r <= 2'h3;
         rx_sync_r <= 2'h3;
         rx_prev_r <= 1'b1;
      end else begin
         sel_sync_r <= {sel_sync_r[0], i_boot_select_pin};
         rx_sync_r <= {rx_sync_r[0], i_serial_receive_pin};
         rx_prev_r <= rx_sync_r[1];
      end
   end

   assign rx_s = rx_sync_r[1];
   assign rx_fall = rx_prev_r && !rx_s;
   assign rx_rise = !rx_prev_r && rx_s;
   assign bit_clks = `SBL_BIT_MULT * (21'(o_baud_reload_value) + 21'h000001);
   assign rx_en = (state_r == SBL_ST_LOAD) || (state_r == SBL_ST_RUN);
   assign load_take = o_load_valid && i_load_ready;

   // ***************************************************************
   // Mode sequencer
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= SBL_ST_POR;
         smp_cnt_r <= 2'h0;
      end else if (i_sw_reset) begin
         state_r <= SBL_ST_NORMAL;
      end else begin
         unique case (state_r)
            SBL_ST_POR: begin
               // Wait out the synchroniser before trusting the select level
               smp_cnt_r <= smp_cnt_r + 2'h1;
               if (smp_cnt_r == `SBL_SAMPLE_DELAY) begin
                  state_r <= sel_sync_r[1] ? SBL_ST_NORMAL : SBL_ST_CAL_WAIT;
               end
            end
            SBL_ST_NORMAL: begin
               state_r <= SBL_ST_NORMAL;
            end
            SBL_ST_CAL_WAIT: begin
               if (rx_fall) begin
                  state_r <= SBL_ST_CAL_MEAS;
               end
            end
            SBL_ST_CAL_MEAS: begin
               if (rx_rise) begin
                  state_r <= SBL_ST_ID_TX;
               end
            end
            SBL_ST_ID_TX: begin
               if (tx_busy_r && tx_idx_r == `SBL_TX_BITS && tx_cnt_r == 21'h0) begin
                  state_r <= SBL_ST_LOAD;
               end
            end
            SBL_ST_LOAD: begin
               if (load_take && o_load_word.to_ram &&
                   load_cnt_r == `SBL_LOAD_BYTES - 6'h1) begin
                  state_r <= SBL_ST_RUN;
               end
            end
            SBL_ST_RUN: begin
               state_r <= SBL_ST_RUN;
            end
            default: begin
               state_r <= SBL_ST_POR;
            end
         endcase
      end
   end

   // ***************************************************************
   // Boot configuration and execution start
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_boot_mode <= 1'b0;
         o_watchdog_disable <= 1'b0;
         o_code_mem_restrict <= 1'b0;
         o_stack_top_pointer <= 16'h0000;
         o_stack_limit_setting <= 16'h0000;
         o_serial_control_setting <= 16'h0000;
         o_transmit_pin_latch <= 1'b0;
         o_transmit_pin_direction <= 1'b0;
         o_exec_start <= 1'b0;
         o_fetch_addr <= `SBL_RESET_FETCH;
      end else begin
         o_exec_start <= 1'b0;
         if (i_sw_reset) begin
            o_boot_mode <= 1'b0;
            o_watchdog_disable <= 1'b0;
            o_code_mem_restrict <= 1'b0;
            o_serial_control_setting <= 16'h0000;
            o_exec_start <= 1'b1;
            o_fetch_addr <= `SBL_RESET_FETCH;
         end else if (state_r == SBL_ST_POR && smp_cnt_r == `SBL_SAMPLE_DELAY) begin
            if (!sel_sync_r[1]) begin
               o_boot_mode <= 1'b1;
               o_watchdog_disable <= 1'b1;
               o_code_mem_restrict <= 1'b1;
               o_stack_top_pointer <= `SBL_STACK_TOP;
               o_stack_limit_setting <= `SBL_STACK_LIMIT;
               o_serial_control_setting <= `SBL_SERIAL_CTRL;
               o_transmit_pin_latch <= 1'b1;
               o_transmit_pin_direction <= 1'b1;
            end else begin
               o_exec_start <= 1'b1;
               o_fetch_addr <= `SBL_RESET_FETCH;
            end
         end else if (state_r == SBL_ST_LOAD && load_take && o_load_word.to_ram &&
                      load_cnt_r == `SBL_LOAD_BYTES - 6'h1) begin
            o_exec_start <= 1'b1;
            o_fetch_addr <= `SBL_LOAD_BASE;
         end
      end
   end

   // ***************************************************************
   // Calibration timer, counts every fourth clock
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         presc_r <= 2'h0;
         tmr_r <= 16'h0000;
         o_calib_overflow <= 1'b0;
         o_baud_reload_value <= 16'h0000;
      end else if (state_r == SBL_ST_CAL_WAIT) begin
         presc_r <= 2'h0;
         tmr_r <= 16'h0000;
      end else if (state_r == SBL_ST_CAL_MEAS) begin
         presc_r <= presc_r + 2'h1;
         if (rx_rise) begin
            o_baud_reload_value <= calc_reload(tmr_r);
         end else if (presc_r == `SBL_TMR_PRESCALE) begin
            // Saturate on overflow; a too-slow host leaves a wrong reload
            if (tmr_r == 16'hFFFF) begin
               o_calib_overflow <= 1'b1;
            end else begin
               tmr_r <= tmr_r + 16'h0001;
            end
         end
      end
   end

   // ***************************************************************
   // Identification transmitter
   // ***************************************************************
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= 21'h0;
         tx_idx_r <= 4'h0;
         tx_shift_r <= 10'h3FF;
         o_serial_transmit_oe <= 1'b0;
      end else if (i_sw_reset) begin
         tx_busy_r <= 1'b0;
         tx_shift_r <= 10'h3FF;
         o_serial_transmit_oe <= 1'b0;
      end else if (state_r == SBL_ST_CAL_MEAS && rx_rise) begin
         // Stop bit first is for shift order: LSB leaves first
         tx_busy_r <= 1'b1;
         tx_shift_r <= {1'b1, ID_BYTE, 1'b0};
         tx_idx_r <= 4'h0;
         tx_cnt_r <= 21'h0;
         o_serial_transmit_oe <= 1'b1;
      end else if (tx_busy_r) begin
         if (tx_cnt_r == bit_clks - 21'h1) begin
            tx_cnt_r <= 21'h0;
            tx_idx_r <= tx_idx_r + 4'h1;
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
         end else begin
            tx_cnt_r <= tx_cnt_r + 21'h1;
         end
         if (tx_idx_r == `SBL_TX_BITS) begin
            tx_busy_r <= 1'b0;
         end
      end
   end

   assign o_serial_transmit_pin = tx_shift_r[0] || !tx_busy_r;

   // ***************************************************************
   // Receiver with a one-byte hold for FIFO back-pressure
   // ***************************************************************
   assign rx_done = rx_busy_r && rx_idx_r == `SBL_DATA_BITS + 4'h1 &&
                    rx_cnt_r == bit_clks - 21'h1;

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= 21'h0;
         rx_idx_r <= 4'h0;
         rx_shift_r <= 8'h00;
      end else if (!rx_en) begin
         rx_busy_r <= 1'b0;
      end else if (!rx_busy_r) begin
         if (rx_fall) begin
            rx_busy_r <= 1'b1;
            rx_idx_r <= 4'h0;
            // Start half a period early so samples land mid-bit
            rx_cnt_r <= bit_clks >> 1;
         end
      end else if (rx_cnt_r == bit_clks - 21'h1) begin
         rx_cnt_r <= 21'h0;
         rx_idx_r <= rx_idx_r + 4'h1;
         if (rx_idx_r == 4'h0 && rx_s) begin
            rx_busy_r <= 1'b0; // False start
         end else if (rx_idx_r <= `SBL_DATA_BITS) begin
            rx_shift_r <= {rx_s, rx_shift_r[7:1]};
         end else begin
            rx_busy_r <= 1'b0;
         end
      end else begin
         rx_cnt_r <= rx_cnt_r + 21'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_pend_r <= 1'b0;
         rx_word_r <= '0;
         push_cnt_r <= 6'h00;
         o_rx_overrun <= 1'b0;
      end else begin
         if (rx_done) begin
            if (rx_pend_r && !fifo_in_ready) begin
               o_rx_overrun <= 1'b1;
            end
            rx_pend_r <= 1'b1;
            rx_word_r.data <= rx_shift_r;
            rx_word_r.to_ram <= (state_r == SBL_ST_LOAD) && (push_cnt_r < `SBL_LOAD_BYTES);
            rx_word_r.addr <= `SBL_LOAD_BASE + 24'(push_cnt_r);
            if (state_r == SBL_ST_LOAD && push_cnt_r < `SBL_LOAD_BYTES) begin
               push_cnt_r <= push_cnt_r + 6'h01;
            end
         end else if (fifo_in_ready) begin
            rx_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         load_cnt_r <= 6'h00;
      end else if (load_take && o_load_word.to_ram) begin
         load_cnt_r <= load_cnt_r + 6'h01;
      end
   end

   sbl_fifo #(
      .WIDTH($bits(sbl_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_in_valid(rx_pend_r),
      .o_in_ready(fifo_in_ready),
      .i_in_data(rx_word_r),
      .o_out_valid(o_load_valid),
      .i_out_ready(i_load_ready),
      .o_out_data(o_load_word)
   );

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   property p_boot_entry;
      state_r == SBL_ST_POR && smp_cnt_r == `SBL_SAMPLE_DELAY && !sel_sync_r[1] && !i_sw_reset
         |=> o_boot_mode && state_r == SBL_ST_CAL_WAIT;
   endproperty
   a_boot_entry: assert property (p_boot_entry) else $error("boot entry missed");

   // Floor bounds, so the check does not lean on the design's own divider
   property p_reload;
      state_r == SBL_ST_CAL_MEAS && rx_rise && !i_sw_reset
         |=> state_r == SBL_ST_ID_TX &&
         (($past(tmr_r) < 16'h0024 && o_baud_reload_value == 16'h0000) ||
          (32'(o_baud_reload_value) * 32'h00000048 + 32'h00000024 <= 32'($past(tmr_r)) &&
           32'($past(tmr_r)) < 32'(o_baud_reload_value) * 32'h00000048 + 32'h0000006C));
   endproperty
   a_reload: assert property (p_reload) else $error("reload value wrong");

   property p_bit_period;
      $rose(tx_busy_r) |-> ##1 (!o_serial_transmit_pin)[*2] ##0
         bit_clks == 21'h000020 * (21'(o_baud_reload_value) + 21'h000001);
   endproperty
   a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

   // Each bit boundary lands one full period after the previous one
   property p_bit_len;
      tx_busy_r && tx_cnt_r == 21'h000000 && tx_idx_r != 4'h0 |->
         $past(tx_cnt_r) == 21'h000020 * (21'(o_baud_reload_value) + 21'h000001) - 21'h000001;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit length wrong");

   property p_id_tx;
      $rose(tx_busy_r) |-> o_serial_transmit_oe && tx_shift_r[8:1] == ID_BYTE;
   endproperty
   a_id_tx: assert property (p_id_tx) else $error("id byte not sent");

   property p_presets;
      $rose(o_boot_mode) |-> o_stack_top_pointer == 16'hFA40 &&
         o_stack_limit_setting == 16'hFA0C && o_serial_control_setting == 16'h8011 &&
         o_transmit_pin_latch && o_transmit_pin_direction;
   endproperty
   a_presets: assert property (p_presets) else $error("boot presets wrong");

   property p_wdt_off;
      o_boot_mode |-> o_watchdog_disable && o_code_mem_restrict;
   endproperty
   a_wdt_off: assert property (p_wdt_off) else $error("watchdog on in boot");

   property p_load_addr;
      load_take && o_load_word.to_ram |->
         o_load_word.addr == 24'h00FA40 + 24'(load_cnt_r) && o_load_word.addr <= 24'h00FA5F;
   endproperty
   a_load_addr: assert property (p_load_addr) else $error("load address wrong");

   property p_exec;
      state_r == SBL_ST_LOAD && load_take && o_load_word.to_ram && load_cnt_r == 6'h1F &&
         !i_sw_reset |=> o_exec_start && o_fetch_addr == 24'h00FA40 ##1 !o_exec_start &&
         o_boot_mode && state_r == SBL_ST_RUN;
   endproperty
   a_exec: assert property (p_exec) else $error("execution start wrong");

   property p_sw_exit;
      i_sw_reset |=> !o_boot_mode && o_exec_start && o_fetch_addr == 24'h000000;
   endproperty
   a_sw_exit: assert property (p_sw_exit) else $error("software reset exit wrong");

   c_boot: cover property ($rose(o_boot_mode));
   c_id_done: cover property (state_r == SBL_ST_ID_TX ##1 state_r == SBL_ST_LOAD);
   c_run: cover property ($rose(state_r == SBL_ST_RUN));
   c_fifo_full: cover property (rx_pend_r && !fifo_in_ready);

endmodule

// ### sim/sbl_host.sv
// Host model: sends serial frames to the loader and receives its reply byte.
// Assumes one core clock; all timing is counted in core clock cycles.
module sbl_host (
   input wire logic i_mclk,
   input wire logic i_tx,
   input wire logic i_tx_oe,
   output logic o_rx
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle line is high between frames, like a real host
   initial o_rx = 1'b1;

   // ***************************************************************
   // Frame sender: start, eight data bits LSB first, stop
   // ***************************************************************
   task automatic send_byte(input logic [7:0] b, input int bit_clks);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_mclk);
         #1;
         o_rx = frame[i];
         repeat (bit_clks - 1) @(posedge i_mclk);
      end
   endtask

   // ***************************************************************
   // Frame receiver: bounded wait for start, mid-bit sampling
   // ***************************************************************
   task automatic recv_byte(input int bit_clks, output logic [7:0] b, output bit ok);
      int n;
      ok = 0;
      b = 8'h00;
      for (n = 0; n < 4000 && !(i_tx_oe === 1'b1 && i_tx === 1'b0); n++) @(posedge i_mclk);
      if (n == 4000) return;
      repeat (bit_clks / 2) @(posedge i_mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_clks) @(posedge i_mclk);
         b[i] = i_tx;
      end
      repeat (bit_clks) @(posedge i_mclk);
      ok = (i_tx === 1'b1);
      // Receiver of the loader is enabled only after the stop bit
      repeat (bit_clks) @(posedge i_mclk);
   endtask
endmodule

// ### sim/sbl_loader_tb.sv
// Testbench of the serial boot loader: boot entry, calibration, load, exits.
// Assumes the host model in its own file and the design's package compiled first.
module sbl_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbl_pkg::*;

   localparam logic [7:0] ID = 8'h6A; // Arbitrary identification value
   // Fast host, far from timer overflow
   localparam int HOST_BIT = 64;
   localparam int EXP_RELOAD = (9 * HOST_BIT / 4 - 36) / 72;
   localparam int DEV_BIT = 32 * (EXP_RELOAD + 1);

   logic i_mclk = 1'b0, i_rst_b, i_sw_reset, i_boot_select_pin, i_load_ready;
   logic i_serial_receive_pin, o_serial_transmit_pin, o_serial_transmit_oe;
   logic o_transmit_pin_latch, o_transmit_pin_direction, o_boot_mode, o_watchdog_disable;
   logic o_code_mem_restrict, o_calib_overflow, o_rx_overrun, o_exec_start, o_load_valid;
   logic [15:0] o_stack_top_pointer, o_stack_limit_setting, o_serial_control_setting;
   logic [15:0] o_baud_reload_value;
   logic [23:0] o_fetch_addr, exec_addr;
   sbl_word_t o_load_word;
   sbl_word_t words[$];
   int err_total = 0, n_compared = 0, exec_cnt = 0;

   sbl_loader #(.ID_BYTE(ID), .FIFO_DEPTH(4)) dut (
      .i_mclk, .i_rst_b, .i_sw_reset, .i_boot_select_pin, .i_serial_receive_pin,
      .o_serial_transmit_pin, .o_serial_transmit_oe, .o_transmit_pin_latch,
      .o_transmit_pin_direction, .o_boot_mode, .o_watchdog_disable, .o_code_mem_restrict,
      .o_stack_top_pointer, .o_stack_limit_setting, .o_serial_control_setting,
      .o_baud_reload_value, .o_calib_overflow, .o_rx_overrun, .o_exec_start, .o_fetch_addr,
      .o_load_valid, .i_load_ready, .o_load_word);

   sbl_host host (.i_mclk(i_mclk), .i_tx(o_serial_transmit_pin),
      .i_tx_oe(o_serial_transmit_oe), .o_rx(i_serial_receive_pin));

   always #5 i_mclk = ~i_mclk;

   // ***************************************************************
   // Monitors and helpers
   // ***************************************************************
   always @(posedge i_mclk) begin
      if (o_load_valid === 1'b1 && i_load_ready === 1'b1) words.push_back(o_load_word);
      if (o_exec_start === 1'b1) begin
         exec_cnt++;
         exec_addr = o_fetch_addr;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      if (err_total == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   function automatic logic [7:0] code_of(input int i);
      return 8'((i * 37) + 5);
   endfunction

   task automatic hw_reset(input logic sel);
      // Other configuration pins are taken as held at boot levels
      cyc(1);
      i_rst_b = 1'b0;
      i_boot_select_pin = sel;
      exec_cnt = 0;
      cyc(5);
      i_rst_b = 1'b1;
      cyc(10);
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_boot_entry;
      chk("boot_mode", 1, o_boot_mode);
      chk("stack_top", 32'hFA40, o_stack_top_pointer);
      chk("stack_limit", 32'hFA0C, o_stack_limit_setting);
      chk("serial_ctrl", 32'h8011, o_serial_control_setting);
      chk("latch_dir", 3, {o_transmit_pin_latch, o_transmit_pin_direction});
      chk("tx_oe_early", 0, o_serial_transmit_oe);
      chk("wdt_off", 1, o_watchdog_disable);
      chk("code_restrict", 1, o_code_mem_restrict);
      chk("no_exec", 0, exec_cnt);
   endtask

   task automatic t_calibrate;
      logic [7:0] id;
      bit ok;
      fork
         host.send_byte(8'h00, HOST_BIT);
         host.recv_byte(DEV_BIT, id, ok);
      join
      chk("reload", EXP_RELOAD, o_baud_reload_value);
      chk("id_frame", 1, ok);
      chk("id_byte", ID, id);
      chk("tx_oe", 1, o_serial_transmit_oe);
      chk("calib_ovf", 0, o_calib_overflow);
      // A wait that ran out or a low stop bit on the reply frame leaves ok clear
      if (!ok) tally_and_finish();
   endtask

   task automatic t_load;
      sbl_word_t w;
      int n;
      // Sink stalls for the first bytes so the buffer backs up
      for (int i = 0; i < 32; i++) begin
         cyc(1);
         i_load_ready = (i >= 3);
         host.send_byte(code_of(i), DEV_BIT);
      end
      for (n = 0; n < 300 && exec_cnt == 0; n++) cyc(1);
      chk("exec_count", 1, exec_cnt);
      if (n == 300) tally_and_finish();
      chk("exec_addr", 32'hFA40, exec_addr);
      chk("load_count", 32, words.size());
      for (int i = 0; i < 32 && words.size() > 0; i++) begin
         w = words.pop_front();
         chk("load_ram", 1, w.to_ram);
         chk("load_addr", 32'hFA40 + i, w.addr);
         chk("load_data", code_of(i), w.data);
      end
      chk("boot_kept", 1, o_boot_mode);
      chk("wdt_kept", 1, o_watchdog_disable);
      chk("ctrl_kept", 32'h8011, o_serial_control_setting);
   endtask

   task automatic t_overrun;
      sbl_word_t w;
      i_load_ready = 1'b0;
      for (int i = 0; i < 5; i++) host.send_byte(code_of(i + 40), DEV_BIT);
      cyc(10);
      chk("overrun_full", 0, o_rx_overrun);
      chk("valid_stall", 1, o_load_valid);
      host.send_byte(8'hE7, DEV_BIT);
      cyc(10);
      chk("overrun_set", 1, o_rx_overrun);
      i_load_ready = 1'b1;
      cyc(10);
      chk("drained", 5, words.size());
      while (words.size() > 0) begin
         w = words.pop_front();
         chk("after_ram", 0, w.to_ram);
      end
      chk("run_exec", 1, exec_cnt);
   endtask

   task automatic t_sw_reset;
      i_boot_select_pin = 1'b0;
      i_sw_reset = 1'b1;
      cyc(1);
      i_sw_reset = 1'b0;
      cyc(2);
      chk("sw_exec", 2, exec_cnt);
      chk("sw_fetch", 0, exec_addr);
      chk("sw_boot", 0, o_boot_mode);
      chk("sw_wdt", 0, o_watchdog_disable);
   endtask

   task automatic t_normal;
      chk("hw_exec", 1, exec_cnt);
      chk("hw_fetch", 0, exec_addr);
      chk("hw_boot", 0, o_boot_mode);
      host.send_byte(8'h00, HOST_BIT);
      cyc(20);
      chk("normal_oe", 0, o_serial_transmit_oe);
      chk("normal_reload", 0, o_baud_reload_value);
   endtask

   initial begin
      i_rst_b = 1'b0;
      i_sw_reset = 1'b0;
      i_boot_select_pin = 1'b0;
      i_load_ready = 1'b1;
      hw_reset(1'b0);
      t_boot_entry();
      t_calibrate();
      t_load();
      t_overrun();
      t_sw_reset();
      hw_reset(1'b1);
      t_normal();
      tally_and_finish();
   end
endmodule
